// >>> logic/erx_map.svh
`ifndef ERX_MAP_SVH
`define ERX_MAP_SVH

// Core clock
`define ERX_CLK_MHZ 25
// Internal receive clock period, and its length in core cycles
`define ERX_INT_PERIOD_NS 320
`define ERX_INT_DIV ((`ERX_INT_PERIOD_NS * `ERX_CLK_MHZ) / 1000)
// Dead time of the clock changeover, least time, rounded up
`define ERX_GAP_NS 80
`define ERX_GAP_CYC ((`ERX_GAP_NS * `ERX_CLK_MHZ + 999) / 1000)

// Bit positions of the pin synchroniser vectors
`define ERX_PIN_CLK 0
`define ERX_PIN_EN 1
`define ERX_PIN_DAT 2
`define ERX_PIN_ERR 3

// FIFO word layout and shape
`define ERX_WORD_W 10
`define ERX_WORD_LAST 9
`define ERX_WORD_ERR 8
`define ERX_FIFO_DEPTH 16

`endif

// >>> logic/erx_pkg.sv
package erx_pkg;

	// Clock changeover states, Gray coded around the loop
	typedef enum logic [1:0] {
		ERX_SEL_INT = 2'h0,
		ERX_SEL_TO_EXT = 2'h1,
		ERX_SEL_EXT = 2'h3,
		ERX_SEL_TO_INT = 2'h2
	} erx_sel_t;

	typedef struct packed {
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic [3:0] pin_s3;
		logic [3:0] lvl;
		erx_sel_t sel;
		logic [3:0] gap_cnt;
		logic [7:0] div_cnt;
		logic int_tick;
		logic bit_tick;
		logic frame;
		logic [7:0] shreg;
		logic [2:0] bit_cnt;
		logic [7:0] hold;
		logic hold_vld;
		logic err_seen;
		logic overrun;
		logic push_vld;
		logic [9:0] push_word;
		logic ext_sel;
		logic tick;
	} erx_rx_st_t;

endpackage : erx_pkg

// >>> logic/erx_fifo.sv
`timescale 1ns/1ns
`include "erx_map.svh"

module erx_fifo #(
	parameter int W = `ERX_WORD_W,
	parameter int D = `ERX_FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic in_valid_in,
	input wire logic [W-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [W-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic ovld;
		logic [W-1:0] odata;
	} erx_fifo_st_t;

	erx_fifo_st_t st_ff;
	erx_fifo_st_t nxt_st;
	logic [AW:0] fill;
	logic full;
	logic empty;

	// Fill level from the wrap-extended pointers
	assign fill = st_ff.wp - st_ff.rp;
	assign full = (fill == (AW + 1)'(D));
	assign empty = (fill == '0);
	assign in_ready_out = !full;
	assign out_valid_out = st_ff.ovld;
	assign out_data_out = st_ff.odata;

	// Output register refills whenever drained, so the reader sees no bubble
	always_comb begin
		nxt_st = st_ff;
		if (in_valid_in && !full) begin
			nxt_st.mem[st_ff.wp[AW-1:0]] = in_data_in;
			nxt_st.wp = st_ff.wp + 1'b1;
		end
		if (st_ff.ovld && out_ready_in) begin
			nxt_st.ovld = 1'b0;
		end
		if (!empty && (!st_ff.ovld || out_ready_in)) begin
			nxt_st.odata = st_ff.mem[st_ff.rp[AW-1:0]];
			nxt_st.ovld = 1'b1;
			nxt_st.rp = st_ff.rp + 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : erx_fifo

// >>> logic/erx_rx.sv
`timescale 1ns/1ns
`include "erx_map.svh"

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module erx_rx (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic rx_clk_in,
	input wire logic receive_enable_input_in,
	input wire logic rx_data_in,
	input wire logic receive_error_input_in,
	input wire logic loopback_in,
	input wire logic lb_frame_in,
	input wire logic lb_bit_valid_in,
	input wire logic lb_bit_in,
	output logic [7:0] rx_byte_out,
	output logic rx_last_out,
	output logic rx_crc_err_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in,
	output logic rx_ext_clk_sel_out,
	output logic rx_clk_tick_out,
	output logic rx_frame_out,
	output logic rx_overrun_out
);

	erx_pkg::erx_rx_st_t st_ff;
	erx_pkg::erx_rx_st_t nxt_st;
	logic fifo_ready;
	logic [`ERX_WORD_W-1:0] fifo_word;

	// Pack one FIFO word
	function automatic logic [`ERX_WORD_W-1:0] erx_word(
		input logic last,
		input logic err,
		input logic [7:0] data
	);
		erx_word = {last, err, data};
	endfunction : erx_word

	////////////////////////////////////////////////////////////////////////////
	// Receive state
	always_comb begin
		logic [3:0] new_lvl;
		logic ext_rise;
		logic src_en;
		logic src_strobe;
		logic src_bit;
		logic [7:0] new_byte;
		logic push_busy;
		new_lvl = '0;
		ext_rise = 1'b0;
		src_en = 1'b0;
		src_strobe = 1'b0;
		src_bit = 1'b0;
		new_byte = '0;
		push_busy = 1'b0;
		nxt_st = st_ff;

		// Three-stage pin sampling; a level counts once stages two and three agree
		nxt_st.pin_s1 = {receive_error_input_in, rx_data_in, receive_enable_input_in, rx_clk_in};
		nxt_st.pin_s2 = st_ff.pin_s1;
		nxt_st.pin_s3 = st_ff.pin_s2;
		for (int i = 0; i < 4; i++) begin
			new_lvl[i] = (st_ff.pin_s2[i] == st_ff.pin_s3[i]) ? st_ff.pin_s3[i] : st_ff.lvl[i];
		end
		nxt_st.lvl = new_lvl;
		ext_rise = new_lvl[`ERX_PIN_CLK] && !st_ff.lvl[`ERX_PIN_CLK];

		// Pushed word leaves once the FIFO takes it
		push_busy = st_ff.push_vld && !fifo_ready;
		nxt_st.push_vld = push_busy;

		// Clock select: edges pass only in the settled states
		nxt_st.int_tick = 1'b0;
		nxt_st.bit_tick = 1'b0;
		if (st_ff.gap_cnt != 4'h0) begin
			nxt_st.gap_cnt = st_ff.gap_cnt - 4'h1;
		end
		unique case (st_ff.sel)
			erx_pkg::ERX_SEL_INT: begin
				// Internal divider runs the idle receive logic
				if (st_ff.div_cnt == 8'(`ERX_INT_DIV - 1)) begin
					nxt_st.div_cnt = 8'h00;
					nxt_st.int_tick = 1'b1;
				end else begin
					nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
				end
				if (new_lvl[`ERX_PIN_EN] && !loopback_in) begin
					nxt_st.sel = erx_pkg::ERX_SEL_TO_EXT;
					nxt_st.gap_cnt = 4'(`ERX_GAP_CYC);
				end
			end
			erx_pkg::ERX_SEL_TO_EXT: begin
				// Dead time: neither source reaches the logic
				if (st_ff.gap_cnt == 4'h0) begin
					nxt_st.sel = erx_pkg::ERX_SEL_EXT;
				end
			end
			erx_pkg::ERX_SEL_EXT: begin
				nxt_st.bit_tick = ext_rise && new_lvl[`ERX_PIN_EN];
				// Enable low blocks stray edges at once, before the switch settles
				if (!new_lvl[`ERX_PIN_EN] || loopback_in) begin
					nxt_st.bit_tick = 1'b0;
					nxt_st.sel = erx_pkg::ERX_SEL_TO_INT;
					nxt_st.gap_cnt = 4'(`ERX_GAP_CYC);
				end
			end
			erx_pkg::ERX_SEL_TO_INT: begin
				// Late framer pulses land here and are dropped
				if (st_ff.gap_cnt == 4'h0) begin
					nxt_st.sel = erx_pkg::ERX_SEL_INT;
					nxt_st.div_cnt = 8'h00;
				end
			end
		endcase

		// Source mux: looped data never looks at the pins
		if (loopback_in) begin
			src_en = lb_frame_in;
			src_strobe = lb_bit_valid_in && lb_frame_in;
			src_bit = lb_bit_in;
		end else begin
			src_en = new_lvl[`ERX_PIN_EN];
			src_strobe = st_ff.bit_tick;
			src_bit = st_ff.lvl[`ERX_PIN_DAT];
		end
		nxt_st.frame = src_en;

		// Frame start clears per-frame status
		if (src_en && !st_ff.frame) begin
			nxt_st.bit_cnt = 3'h0;
			nxt_st.hold_vld = 1'b0;
			nxt_st.err_seen = 1'b0;
			nxt_st.overrun = 1'b0;
		end

		// Error input counts only on a pin-fed frame
		if (st_ff.frame && !loopback_in && st_ff.lvl[`ERX_PIN_ERR]) begin
			nxt_st.err_seen = 1'b1;
		end

		// Byte assembly, LSB first
		if (st_ff.frame && src_strobe) begin
			new_byte = {src_bit, st_ff.shreg[7:1]};
			nxt_st.shreg = new_byte;
			nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
			if (st_ff.bit_cnt == 3'h7) begin
				// One byte is held back so the last one can be marked
				if (st_ff.hold_vld) begin
					if (push_busy) begin
						nxt_st.overrun = 1'b1;
					end else begin
						nxt_st.push_vld = 1'b1;
						nxt_st.push_word = erx_word(1'b0, 1'b0, st_ff.hold);
					end
				end
				nxt_st.hold = new_byte;
				nxt_st.hold_vld = 1'b1;
			end
		end

		// Frame end flushes the held byte with the frame status; partial bits drop
		if (st_ff.frame && !src_en) begin
			if (st_ff.hold_vld) begin
				if (push_busy) begin
					nxt_st.overrun = 1'b1;
				end else begin
					nxt_st.push_vld = 1'b1;
					nxt_st.push_word = erx_word(1'b1, st_ff.err_seen, st_ff.hold);
				end
			end
			nxt_st.hold_vld = 1'b0;
		end

		// Status outputs get their own flops, so no decode logic reaches a pin
		nxt_st.ext_sel = (nxt_st.sel == erx_pkg::ERX_SEL_EXT);
		nxt_st.tick = nxt_st.bit_tick | nxt_st.int_tick;
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte FIFO; a stalled reader holds the push word and then flags overrun
	erx_fifo #(
		.W(`ERX_WORD_W),
		.D(`ERX_FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.in_valid_in(st_ff.push_vld),
		.in_data_in(st_ff.push_word),
		.in_ready_out(fifo_ready),
		.out_valid_out(rx_valid_out),
		.out_data_out(fifo_word),
		.out_ready_in(rx_ready_in)
	);

	// Outputs, all from state flip-flops
	assign rx_byte_out = fifo_word[7:0];
	assign rx_last_out = fifo_word[`ERX_WORD_LAST];
	assign rx_crc_err_out = fifo_word[`ERX_WORD_ERR];
	assign rx_ext_clk_sel_out = st_ff.ext_sel;
	assign rx_clk_tick_out = st_ff.tick;
	assign rx_frame_out = st_ff.frame;
	assign rx_overrun_out = st_ff.overrun;

endmodule : erx_rx

// >>> tb/erx_phy.sv
`timescale 1ns/1ns
// Far-side framer; its clock stands still between frames
module erx_phy (
	output logic rx_clk_out,
	output logic ena_out,
	output logic dat_out,
	output logic err_out
);
	initial begin
		rx_clk_out = 1'h0;
		ena_out = 1'h0;
		dat_out = 1'h0;
		err_out = 1'h0;
	end
	// LSB first; tail gives stray edges after enable drops, as some framers do
	task send(input logic [15:0] d, input int nb, input logic e, input int tail);
		ena_out <= 1'h1;
		err_out <= e;
		#207;
		for (int i = 0; i < 8 * nb; i++) begin
			dat_out <= d[i];
			#160 rx_clk_out <= 1'h1;
			#160 rx_clk_out <= 1'h0;
		end
		ena_out <= 1'h0;
		dat_out <= ~dat_out;
		for (int i = 0; i < tail; i++) begin
			#160 rx_clk_out <= 1'h1;
			#160 rx_clk_out <= 1'h0;
		end
		err_out <= 1'h0; // Low outside its own error frames
		#400;
	endtask : send
endmodule : erx_phy

// >>> tb/erx_rx_chk.sv
`timescale 1ns/1ns
module erx_rx_chk (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic loopback_in,
	input wire logic lb_frame_in,
	input wire logic rx_last_out,
	input wire logic rx_crc_err_out,
	input wire logic rx_valid_out,
	input wire logic rx_ext_clk_sel_out,
	input wire logic rx_clk_tick_out,
	input wire logic rx_frame_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// Loopback idle long enough for the frame flag to settle
	sequence lb_idle;
		(loopback_in && !lb_frame_in) [*2];
	endsequence
	// Changeover away from the pin clock
	sequence leave_ext;
		$fell(rx_ext_clk_sel_out);
	endsequence
	a_lb_int_clk: assert property (loopback_in |-> !rx_ext_clk_sel_out)
		else $error("pin clock selected in loopback");
	a_lb_no_frame: assert property (lb_idle |-> !rx_frame_out)
		else $error("pin frame seen in loopback");
	a_lb_no_crc: assert property (loopback_in && rx_valid_out && rx_last_out |-> !rx_crc_err_out)
		else $error("crc error in loopback");
	a_ext_tick_gap: assert property (rx_clk_tick_out && rx_ext_clk_sel_out |=> !rx_clk_tick_out [*5])
		else $error("pin ticks too close");
	a_end_to_int: assert property ($fell(rx_frame_out) && !loopback_in |-> ##[0:3] !rx_ext_clk_sel_out)
		else $error("no change to internal clock");
	a_break_gap: assert property (leave_ext |=> !rx_clk_tick_out [*2])
		else $error("tick inside dead time");
endmodule : erx_rx_chk

bind erx_rx erx_rx_chk u_chk (.clk_in, .rst_b_in, .loopback_in, .lb_frame_in, .rx_last_out,
	.rx_crc_err_out, .rx_valid_out, .rx_ext_clk_sel_out, .rx_clk_tick_out, .rx_frame_out);

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
	logic clk_in = 1'h0;
	logic rst_b_in = 1'h0;
	logic loopback_in = 1'h0;
	logic lb_frame_in = 1'h0;
	logic lb_bit_valid_in = 1'h0;
	logic lb_bit_in = 1'h0;
	logic rx_ready_in = 1'h0;
	logic rx_clk, ena, dat, err;
	logic [7:0] rx_byte_out;
	logic rx_last_out, rx_crc_err_out, rx_valid_out, rx_ext_clk_sel_out;
	logic rx_clk_tick_out, rx_frame_out, rx_overrun_out;
	int bad_count = 0;
	int compares = 0;
	// 25 MHz core clock
	always #20 clk_in = ~clk_in;
	erx_phy phy (.rx_clk_out(rx_clk), .ena_out(ena), .dat_out(dat), .err_out(err));
	erx_rx dut (.clk_in, .rst_b_in, .rx_clk_in(rx_clk), .receive_enable_input_in(ena),
		.rx_data_in(dat), .receive_error_input_in(err), .loopback_in, .lb_frame_in,
		.lb_bit_valid_in, .lb_bit_in, .rx_byte_out, .rx_last_out, .rx_crc_err_out,
		.rx_valid_out, .rx_ready_in, .rx_ext_clk_sel_out, .rx_clk_tick_out, .rx_frame_out,
		.rx_overrun_out);
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [10:0] got, input logic [10:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One byte off the stream, as {crc error, last, byte}
	task get(input logic [9:0] exp);
		int n;
		n = 0;
		@(posedge clk_in) rx_ready_in <= 1'h1;
		@(negedge clk_in);
		while (rx_valid_out !== 1'h1 && n < 600) begin
			@(negedge clk_in);
			n++;
		end
		chk("byte", {rx_valid_out, rx_crc_err_out, rx_last_out, rx_byte_out}, {1'h1, exp});
		@(posedge clk_in) rx_ready_in <= 1'h0;
	endtask : get
	// Loopback frame of n bytes counting up from d
	task lb_frame(input logic [7:0] d, input int nb);
		@(posedge clk_in) lb_frame_in <= 1'h1;
		for (int i = 0; i < 8 * nb; i++) begin
			@(posedge clk_in) lb_bit_valid_in <= 1'h1;
			lb_bit_in <= 1'((d + 8'(i / 8)) >> (i % 8));
			@(posedge clk_in) lb_bit_valid_in <= 1'h0;
		end
		@(posedge clk_in) lb_frame_in <= 1'h0;
	endtask : lb_frame
	////////////////////////////////////////////////////////////////////////////////
	task t_pin;
		fork
			phy.send(16'h3CA5, 2, 1'h0, 0);
			begin
				// Well inside the frame, the pin clock must be in charge
				repeat (40) @(negedge clk_in);
				chk("sel in frame", {10'h000, rx_ext_clk_sel_out}, 11'h001);
			end
		join
		get(10'h0A5);
		get(10'h13C);
		@(negedge clk_in);
		chk("sel", {10'h000, rx_ext_clk_sel_out}, 11'h000);
	endtask : t_pin
	task t_tail;
		phy.send(16'h0F81, 2, 1'h1, 3);
		get(10'h081);
		get(10'h30F);
	endtask : t_tail
	task t_fill;
		@(posedge clk_in) loopback_in <= 1'h1;
		lb_frame(8'h01, 20);
		@(negedge clk_in);
		chk("overrun", {10'h000, rx_overrun_out}, 11'h001);
		for (int i = 0; i < 16; i++)
			get(10'(i + 1));
		@(posedge clk_in) rx_ready_in <= 1'h1;
		repeat (12) @(posedge clk_in);
		rx_ready_in <= 1'h0;
		@(negedge clk_in);
		chk("empty", {10'h000, rx_valid_out}, 11'h000);
	endtask : t_fill
	task t_lb;
		fork
			phy.send(16'hFFFF, 2, 1'h1, 2);
			lb_frame(8'h5A, 1);
		join
		get(10'h15A);
		@(negedge clk_in);
		chk("overrun", {10'h000, rx_overrun_out}, 11'h000);
		@(posedge clk_in) loopback_in <= 1'h0;
	endtask : t_lb
	////////////////////////////////////////////////////////////////////////////////
	task test_done;
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// Main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge clk_in);
		rst_b_in <= 1'h1;
		repeat (4) @(posedge clk_in);
		t_pin;
		t_tail;
		t_fill;
		t_lb;
		test_done;
	end
	// Whole run is well under 60 us; a hang is cut off at 200 us
	initial begin
		#200000;
		bad_count++;
		test_done;
	end
endmodule : tb
